// ### design/asrx_params.svh
// Constants of the asynchronous serial receiver: offsets, field positions,
// reset values and oversampling phases. Included by the top module only.
`ifndef ASRX_PARAMS_SVH
`define ASRX_PARAMS_SVH

// Register byte offsets
`define ASRX_OFF_CTRL      8'h00
`define ASRX_OFF_RATE      8'h04
`define ASRX_OFF_WMARK     8'h08
`define ASRX_OFF_STAT      8'h0c
`define ASRX_OFF_DATA      8'h10

// Control register fields
`define ASRX_CTRL_EN       0
`define ASRX_CTRL_LEN9     1
`define ASRX_CTRL_IRQ_EN   2

// Status register fields
`define ASRX_STAT_FULL     0
`define ASRX_STAT_LSE      1
`define ASRX_STAT_PF       2
`define ASRX_STAT_NF       3
`define ASRX_STAT_FE       4
`define ASRX_STAT_AVAIL    5
`define ASRX_STAT_CNT_LSB  8

// Data register flag position (data in bits 8:0)
`define ASRX_DATA_FLAG_LSB 12

// Reset values
`define ASRX_RST_CTRL      3'h0
`define ASRX_RST_RATE      13'h0010
`define ASRX_RST_WMARK     5'h00

// Oversampling phases, counted 1 to 16 within each bit
`define ASRX_PH_FIRST      5'd1
`define ASRX_PH_V1         5'd3
`define ASRX_PH_V2         5'd5
`define ASRX_PH_V3         5'd7
`define ASRX_PH_S1         5'd8
`define ASRX_PH_S2         5'd9
`define ASRX_PH_S3         5'd10
`define ASRX_PH_LAST       5'd16

// Bits per character
`define ASRX_BITS8         4'd8
`define ASRX_BITS9         4'd9

// AXI responses
`define ASRX_RESP_OKAY     2'b00
`define ASRX_RESP_SLVERR   2'b10

`endif

// ### design/asrx_pkg.sv
// Types shared by the asynchronous serial receiver modules.
// Assumes nothing of its surroundings.
package asrx_pkg;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_START,
      ST_DATA,
      ST_STOP
   } asrx_state_t;

   typedef struct packed {
      logic       fe;
      logic       nf;
      logic       pf;
      logic       sync_err_flag;
      logic [8:0] data;
   } asrx_entry_t;

endpackage

// ### design/asrx_rt_div.sv
// Oversampling clock divider: one-cycle enable at sixteen times the baud rate.
// Assumes a single clock and a divisor held stable while enabled.
module asrx_rt_div #(
   parameter int DIV_W = 13
) (
   input  wire logic             mclk_i,
   input  wire logic             rst_i,
   input  wire logic             en_i,
   input  wire logic [DIV_W-1:0] div_i,
   output logic                  tick_o
);

   if (DIV_W < 2) begin : g_chk
      $error("asrx_rt_div: DIV_W too small");
   end

   typedef struct packed {
      logic [DIV_W-1:0] cnt;
      logic             tick;
   } asrx_div_st_t;

   asrx_div_st_t s_q;
   asrx_div_st_t s_d;

   always_comb begin
      s_d      = s_q;
      s_d.tick = 1'b0;
      if (!en_i) begin
         s_d.cnt = '0;
      end else if ((s_q.cnt + 1'b1) >= div_i || div_i == '0) begin
         s_d.cnt  = '0;
         s_d.tick = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + 1'b1;
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick_o = s_q.tick;

endmodule

// ### design/asrx_fifo.sv
// Receive FIFO in flip-flops with valid/ready on both sides and a word count.
// Assumes a single clock; a push into a full FIFO is refused.
module asrx_fifo #(
   parameter int W     = 13,
   parameter int DEPTH = 16,
   parameter int CW    = $clog2(DEPTH + 1)
) (
   input  wire logic          mclk_i,
   input  wire logic          rst_i,
   input  wire logic          in_valid_i,
   output logic               in_ready_o,
   input  wire logic [W-1:0]  in_data_i,
   output logic               out_valid_o,
   input  wire logic          out_ready_i,
   output logic [W-1:0]       out_data_o,
   output logic [CW-1:0]      count_o
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("asrx_fifo: DEPTH must be a power of two of at least 2");
   end

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0]           wr;
      logic [AW-1:0]           rd;
      logic [CW-1:0]           cnt;
   } asrx_fifo_st_t;

   asrx_fifo_st_t s_q;
   asrx_fifo_st_t s_d;
   logic          push;
   logic          pop;

   always_comb begin
      push = in_valid_i && (s_q.cnt != CW'(DEPTH));
      pop  = out_ready_i && (s_q.cnt != '0);
      s_d  = s_q;
      if (push) begin
         s_d.mem[s_q.wr] = in_data_i;
         s_d.wr          = s_q.wr + 1'b1;
      end
      if (pop) begin
         s_d.rd = s_q.rd + 1'b1;
      end
      if (push && !pop) begin
         s_d.cnt = s_q.cnt + 1'b1;
      end else if (pop && !push) begin
         s_d.cnt = s_q.cnt - 1'b1;
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign in_ready_o  = (s_q.cnt != CW'(DEPTH));
   assign out_valid_o = (s_q.cnt != '0);
   assign out_data_o  = s_q.mem[s_q.rd];
   assign count_o     = s_q.cnt;

endmodule

// ### design/asrx_top.sv
// Asynchronous serial receiver with an AXI4-Lite register slave.
// Assumes rxd_i is synchronous to mclk_i; one clock, asynchronous reset.
`include "asrx_params.svh"

module asrx_top #(
   parameter int DIV_W  = 13,
   parameter int FDEPTH = 16
) (
   input  wire logic        mclk_i,
   input  wire logic        rst_i,
   input  wire logic        rxd_i,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             rx_irq_o
);

   localparam int CW = $clog2(FDEPTH + 1);

   if (DIV_W > 16 || CW > 8) begin : g_chk
      $error("asrx_top: DIV_W or FDEPTH out of range");
   end

   typedef struct packed {
      asrx_pkg::asrx_state_t st;
      logic [4:0]            rt;
      logic [3:0]            bitn;
      logic [2:0]            hist;
      logic [1:0]            smp;
      logic [8:0]            shreg;
      logic                  nf;
      logic                  last_one;
      logic                  prev_s;
      logic                  push;
      asrx_pkg::asrx_entry_t pent;
      logic                  rx_en;
      logic                  len9;
      logic                  irq_en;
      logic [DIV_W-1:0]      rate;
      logic [CW-1:0]         wmark;
      logic                  full;
      logic                  irq;
      logic                  aw_got;
      logic                  w_got;
      logic [7:0]            awaddr;
      logic [31:0]           wdata;
      logic [3:0]            wstrb;
      logic                  awready;
      logic                  wready;
      logic                  bvalid;
      logic [1:0]            bresp;
      logic                  arready;
      logic                  rvalid;
      logic [31:0]           rdata;
      logic [1:0]            rresp;
   } asrx_top_st_t;

   asrx_top_st_t          s_q;
   asrx_top_st_t          s_d;
   logic                  tick;
   logic                  fifo_out_valid;
   logic                  fifo_pop;
   asrx_pkg::asrx_entry_t fifo_head;
   logic [CW-1:0]         fifo_cnt;

   asrx_rt_div #(
      .DIV_W (DIV_W)
   ) u_div (
      .mclk_i (mclk_i),
      .rst_i  (rst_i),
      .en_i   (s_q.rx_en),
      .div_i  (s_q.rate),
      .tick_o (tick)
   );

   // Read-only receive buffer
   // A character that meets a full buffer is dropped
   asrx_fifo #(
      .W     ($bits(asrx_pkg::asrx_entry_t)),
      .DEPTH (FDEPTH),
      .CW    (CW)
   ) u_fifo (
      .mclk_i      (mclk_i),
      .rst_i       (rst_i),
      .in_valid_i  (s_q.push),
      .in_ready_o  (),
      .in_data_i   (s_q.pent),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (fifo_pop),
      .out_data_o  (fifo_head),
      .count_o     (fifo_cnt)
   );

   function automatic logic maj3(input logic [2:0] v);
      return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
   endfunction

   function automatic logic split3(input logic [2:0] v);
      return (v != 3'b000) && (v != 3'b111);
   endfunction

   logic       s;
   logic [2:0] vs;
   logic       v;
   logic [3:0] nbits;
   logic       ar_take;
   logic       aw_take;
   logic       w_take;
   logic [7:0] wr_addr;

   always_comb begin
      s_d     = s_q;
      s       = rxd_i;
      vs      = {s_q.smp, s};
      v       = maj3(vs);
      nbits   = s_q.len9 ? `ASRX_BITS9 : `ASRX_BITS8;
      ar_take = s_axi_arvalid && s_q.arready;
      aw_take = s_axi_awvalid && s_q.awready;
      w_take  = s_axi_wvalid && s_q.wready;
      wr_addr = s_q.awaddr;
      fifo_pop = ar_take && (s_axi_araddr == `ASRX_OFF_DATA) && fifo_out_valid;
      s_d.push = 1'b0;

      // Receiver, advanced once per oversample enable
      if (!s_q.rx_en) begin
         s_d.st   = asrx_pkg::ST_IDLE;
         s_d.hist = 3'b000;
      end else if (tick) begin
         s_d.prev_s = s;
         s_d.rt     = s_q.rt + 5'd1;
         case (s_q.st)
            asrx_pkg::ST_IDLE: begin
               s_d.hist = {s_q.hist[1:0], s};
               if (s_q.hist == 3'b111 && !s) begin
                  s_d.st       = asrx_pkg::ST_START;
                  s_d.rt       = `ASRX_PH_FIRST + 5'd1;
                  s_d.nf       = 1'b0;
                  s_d.last_one = 1'b0;
                  s_d.shreg    = '0;
               end
            end
            asrx_pkg::ST_START: begin
               if (s_q.rt == `ASRX_PH_V1 || s_q.rt == `ASRX_PH_V2) begin
                  s_d.smp = {s_q.smp[0], s};
               end
               if (s_q.rt == `ASRX_PH_V3) begin
                  if ((32'(vs[0]) + 32'(vs[1]) + 32'(vs[2])) >= 32'd2) begin
                     s_d.st   = asrx_pkg::ST_IDLE;
                     s_d.hist = 3'b000;
                     s_d.nf   = 1'b0;
                  end else if (vs != 3'b000) begin
                     s_d.nf = 1'b1;
                  end
               end
               // Highs at phases 8 to 10 of the start bit only add noise
               if (s_q.rt >= `ASRX_PH_S1 && s_q.rt <= `ASRX_PH_S3 && s) begin
                  s_d.nf = 1'b1;
               end
               // Phase restarts after the start bit
               if (s_q.rt == `ASRX_PH_LAST) begin
                  s_d.st   = asrx_pkg::ST_DATA;
                  s_d.rt   = `ASRX_PH_FIRST;
                  s_d.bitn = 4'd0;
               end
            end
            asrx_pkg::ST_DATA, asrx_pkg::ST_STOP: begin
               if (s_q.rt == `ASRX_PH_S1 || s_q.rt == `ASRX_PH_S2) begin
                  s_d.smp = {s_q.smp[0], s};
               end
               if (s_q.rt == `ASRX_PH_S3 && s_q.st == asrx_pkg::ST_DATA) begin
                  s_d.shreg[s_q.bitn] = v;
                  s_d.last_one        = v;
                  if (split3(vs)) begin
                     s_d.nf = 1'b1;
                  end
               end
               if (s_q.rt == `ASRX_PH_S3 && s_q.st == asrx_pkg::ST_STOP) begin
                  // Frame with its flags into the buffer
                  // Stop sampled at phase 10 of bit nbits+1
                  s_d.push      = 1'b1;
                  s_d.pent.fe   = !v;
                  s_d.pent.nf   = s_q.nf || split3(vs);
                  s_d.pent.pf   = 1'b0;
                  s_d.pent.sync_err_flag  = 1'b0;
                  s_d.pent.data = s_q.len9 ? s_q.shreg : {1'b0, s_q.shreg[7:0]};
                  if (!v && s_q.shreg == 9'h000) begin
                     s_d.pent.data = 9'h000;
                  end
                  s_d.st   = asrx_pkg::ST_IDLE;
                  s_d.hist = 3'b000;
               end else if (s_q.rt == `ASRX_PH_LAST ||
                            (s_q.rt > `ASRX_PH_S3 && s_q.last_one && s_q.prev_s && !s)) begin
                  // Phase 16 or an early edge opens the next bit
                  s_d.rt       = `ASRX_PH_FIRST + ((s_q.rt == `ASRX_PH_LAST) ? 5'd0 : 5'd1);
                  s_d.last_one = (s_q.rt == `ASRX_PH_LAST) ? s_q.last_one : 1'b0;
                  s_d.bitn     = s_q.bitn + 4'd1;
                  if (s_q.bitn + 4'd1 == nbits) begin
                     s_d.st = asrx_pkg::ST_STOP;
                  end
               end else if (s_q.rt < `ASRX_PH_S1 && s_q.last_one && s_q.prev_s && !s) begin
                  s_d.rt       = `ASRX_PH_FIRST + 5'd1;
                  s_d.last_one = 1'b0;
               end
            end
            default: begin
               s_d.st = asrx_pkg::ST_IDLE;
            end
         endcase
      end

      s_d.full = (fifo_cnt > s_q.wmark);
      s_d.irq  = s_d.full && s_q.irq_en;

      // AXI4-Lite write channel
      if (aw_take) begin
         s_d.aw_got  = 1'b1;
         s_d.awaddr  = s_axi_awaddr;
         s_d.awready = 1'b0;
         wr_addr     = s_axi_awaddr;
      end
      if (w_take) begin
         s_d.w_got  = 1'b1;
         s_d.wdata  = s_axi_wdata;
         s_d.wstrb  = s_axi_wstrb;
         s_d.wready = 1'b0;
      end
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid  = 1'b0;
         s_d.awready = 1'b1;
         s_d.wready  = 1'b1;
      end
      if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
         s_d.aw_got = 1'b0;
         s_d.w_got  = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp  = `ASRX_RESP_OKAY;
         case (wr_addr)
            `ASRX_OFF_CTRL: begin
               if (s_q.wstrb[0]) begin
                  s_d.rx_en  = s_q.wdata[`ASRX_CTRL_EN];
                  s_d.len9   = s_q.wdata[`ASRX_CTRL_LEN9];
                  s_d.irq_en = s_q.wdata[`ASRX_CTRL_IRQ_EN];
               end
            end
            `ASRX_OFF_RATE: begin
               for (int i = 0; i < DIV_W; i++) begin
                  if (s_q.wstrb[i / 8]) begin
                     s_d.rate[i] = s_q.wdata[i];
                  end
               end
            end
            `ASRX_OFF_WMARK: begin
               if (s_q.wstrb[0]) begin
                  s_d.wmark = s_q.wdata[CW-1:0];
               end
            end
            `ASRX_OFF_STAT, `ASRX_OFF_DATA: begin
               s_d.bresp = `ASRX_RESP_OKAY;
            end
            default: begin
               s_d.bresp = `ASRX_RESP_SLVERR;
            end
         endcase
      end

      // AXI4-Lite read channel
      if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid  = 1'b0;
         s_d.arready = 1'b1;
      end
      if (ar_take) begin
         s_d.arready = 1'b0;
         s_d.rvalid  = 1'b1;
         s_d.rresp   = `ASRX_RESP_OKAY;
         s_d.rdata   = '0;
         case (s_axi_araddr)
            `ASRX_OFF_CTRL: begin
               s_d.rdata[`ASRX_CTRL_EN]     = s_q.rx_en;
               s_d.rdata[`ASRX_CTRL_LEN9]   = s_q.len9;
               s_d.rdata[`ASRX_CTRL_IRQ_EN] = s_q.irq_en;
            end
            `ASRX_OFF_RATE: begin
               s_d.rdata[DIV_W-1:0] = s_q.rate;
            end
            `ASRX_OFF_WMARK: begin
               s_d.rdata[CW-1:0] = s_q.wmark;
            end
            `ASRX_OFF_STAT: begin
               s_d.rdata[`ASRX_STAT_FULL]  = s_q.full;
               s_d.rdata[`ASRX_STAT_LSE]   = fifo_out_valid && fifo_head.sync_err_flag;
               s_d.rdata[`ASRX_STAT_PF]    = fifo_out_valid && fifo_head.pf;
               s_d.rdata[`ASRX_STAT_NF]    = fifo_out_valid && fifo_head.nf;
               s_d.rdata[`ASRX_STAT_FE]    = fifo_out_valid && fifo_head.fe;
               s_d.rdata[`ASRX_STAT_AVAIL] = fifo_out_valid;
               s_d.rdata[`ASRX_STAT_CNT_LSB +: CW] = fifo_cnt;
            end
            `ASRX_OFF_DATA: begin
               if (fifo_out_valid) begin
                  s_d.rdata[8:0] = fifo_head.data;
                  s_d.rdata[`ASRX_DATA_FLAG_LSB +: 4] =
                     {fifo_head.fe, fifo_head.nf, fifo_head.pf, fifo_head.sync_err_flag};
               end
            end
            default: begin
               s_d.rresp = `ASRX_RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         s_q         <= '0;
         s_q.st      <= asrx_pkg::ST_IDLE;
         s_q.rt      <= `ASRX_PH_FIRST;
         s_q.rx_en   <= 1'(`ASRX_RST_CTRL >> `ASRX_CTRL_EN);
         s_q.rate    <= DIV_W'(`ASRX_RST_RATE);
         s_q.wmark   <= CW'(`ASRX_RST_WMARK);
         s_q.awready <= 1'b1;
         s_q.wready  <= 1'b1;
         s_q.arready <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign s_axi_awready = s_q.awready;
   assign s_axi_wready  = s_q.wready;
   assign s_axi_bvalid  = s_q.bvalid;
   assign s_axi_bresp   = s_q.bresp;
   assign s_axi_arready = s_q.arready;
   assign s_axi_rvalid  = s_q.rvalid;
   assign s_axi_rdata   = s_q.rdata;
   assign s_axi_rresp   = s_q.rresp;
   assign rx_irq_o      = s_q.irq;

endmodule

// ### testbench/asrx_properties.sv
// Checker of the register-bus handshakes seen at the receiver's top ports.
// Assumes one clock and the active-high asynchronous reset of the top.
module asrx_properties (
   input wire logic        mclk_i,
   input wire logic        rst_i,
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        rx_irq_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   wire aw_t = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   wire ar_t = s_axi_arvalid && s_axi_arready;
   a_read_answer: assert property (ar_t |=> s_axi_rvalid)
      else $error("read answer late");
   a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_read_blocks: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address open during answer");
   a_read_unmapped: assert property (ar_t && s_axi_araddr > 8'h13 |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
      else $error("unmapped read answered");
   a_write_answer: assert property (aw_t |=> !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write answer timing");
   a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_write_blocks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write channels open during answer");
   a_write_unmapped: assert property (aw_t && s_axi_awaddr > 8'h13 |-> ##2 s_axi_bresp == 2'b10)
      else $error("unmapped write answered");
   c_read: cover property (ar_t);
   c_write: cover property (aw_t && s_axi_awaddr == 8'h00);
   c_irq: cover property ($rose(rx_irq_o));
endmodule

bind asrx_top asrx_properties asrx_properties_inst (.mclk_i, .rst_i, .s_axi_awaddr, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_irq_o);

// ### testbench/asrx_line_model.sv
// Remote transmitter driving the receive line, one sample per clock.
// Assumes the receiver's oversample divisor is one; the line idles high.
module asrx_line_model (
   input  wire logic mclk_i,
   output logic      rxd_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial rxd_o = 1'b1;
   // Low start, LSB first, stop level, bit length bl
   task automatic send(input logic [8:0] d, input int nb, input logic stp, input int bl, input int gp);
      logic v;
      for (int i = 0; i < (nb + 2) * bl; i++) begin
         v = (i < bl) ? 1'b0 : (i >= (nb + 1) * bl) ? stp : d[i / bl - 1];
         @(posedge mclk_i);
         rxd_o <= v ^ (i == gp);
      end
      pulse(0);
   endtask
   // Short low pulse followed by idle line
   task automatic pulse(input int n);
      repeat (n) @(posedge mclk_i) rxd_o <= 1'b0;
      repeat (20) @(posedge mclk_i) rxd_o <= 1'b1;
   endtask
endmodule

// ### testbench/tb_async_serial_receiver.sv
// Self-checking bench of the receiver: register bus tasks and line frames.
// Assumes the line model in its own file and one sample per clock.
module tb_async_serial_receiver;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk_i, rst_i, rxd_i, rx_irq_o;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   int          n_fail, checked, cnt;
   logic [8:0]  td[7] = '{9'h0a4, 9'h03c, 9'h05a, 9'h000, 9'h081, 9'h055, 9'h066};
   logic        ts[7] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
   int          tl[7] = '{16, 16, 16, 16, 16, 15, 16};
   int          tg[7] = '{24, 2, 152, -1, -1, -1, 8};
   logic [15:0] tx[7] = '{16'h40a4, 16'h403c, 16'h405a, 16'h8000, 16'h8081, 16'h0055, 16'h4066};

   asrx_top #(.DIV_W(13), .FDEPTH(16)) asrx_top_inst (.mclk_i, .rst_i, .rxd_i, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .rx_irq_o);
   asrx_line_model asrx_line_model_inst (.mclk_i, .rxd_o(rxd_i));

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         n_fail++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic test_done;
      $display("Checks %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'b00, input int w = 0);
      int n;
      @(posedge mclk_i);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= (w == 0);
      for (n = 0; n < 50 && !(s_axi_bvalid === 1'b1 && s_axi_bready); n++) begin
         @(posedge mclk_i);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (n + 1 == w) s_axi_bready <= 1'b1;
      end
      s_axi_bready <= 1'b0;
      if (n == 50) begin
         n_fail++;
         test_done;
      end
      chk(32'(s_axi_bresp), 32'(r));
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'b00, input int w = 0);
      int n;
      @(posedge mclk_i);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= (w == 0);
      for (n = 0; n < 50 && !(s_axi_rvalid === 1'b1 && s_axi_rready); n++) begin
         @(posedge mclk_i);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (n + 1 == w) s_axi_rready <= 1'b1;
      end
      s_axi_rready <= 1'b0;
      if (n == 50) begin
         n_fail++;
         test_done;
      end
      chk(s_axi_rdata, e);
      chk(32'(s_axi_rresp), 32'(r));
   endtask
   // Frame, then status with interrupt, then a pop when full
   task automatic fr(input logic [8:0] d, input int nb, input logic stp, input int bl, input int gp,
                     input logic [31:0] st, input logic [31:0] dat);
      asrx_line_model_inst.send(d, nb, stp, bl, gp);
      rd(8'h0c, st);
      chk(32'(rx_irq_o), 32'(st[0]));
      if (st[0]) rd(8'h10, dat);
   endtask

   initial begin
      mclk_i = 1'b0;
      forever #4 mclk_i = ~mclk_i;
   end
   initial begin
      {rst_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hf;
      n_fail = 0;
      checked = 0;
      repeat (10) @(posedge mclk_i);
      rst_i <= 1'b0;
      rd(8'h00, 32'h0);
      rd(8'h04, 32'h10, 2'b00, 4);
      rd(8'h08, 32'h0);
      rd(8'h0c, 32'h0);
      rd(8'h20, 32'h0, 2'b10);
      wr(8'h20, 32'h1, 2'b10);
      wr(8'h10, 32'h1ff);
      rd(8'h0c, 32'h0);
      wr(8'h04, 32'h1, 2'b00, 4);
      wr(8'h00, 32'h5);
      // Start search needs three idle samples after enable
      asrx_line_model_inst.pulse(0);
      cnt = 0;
      fork
         fr(9'h0a5, 8, 1'b1, 16, -1, 32'h121, 32'h0a5);
         while (rx_irq_o !== 1'b1 && cnt < 300) @(posedge mclk_i) cnt++;
      join
      chk(32'(cnt >= 155 && cnt <= 162), 32'h1);
      for (int i = 0; i < 7; i++)
         fr(td[i], 8, ts[i], tl[i], tg[i], 32'h121 | (32'(tx[i][15:14]) << 3), 32'(tx[i]));
      asrx_line_model_inst.pulse(4);
      fr(9'h033, 8, 1'b1, 16, -1, 32'h121, 32'h033);
      wr(8'h00, 32'h7);
      fr(9'h1c3, 9, 1'b1, 16, -1, 32'h121, 32'h1c3);
      wr(8'h08, 32'h1);
      fr(9'h011, 9, 1'b1, 16, -1, 32'h120, 32'h0);
      fr(9'h122, 9, 1'b1, 16, -1, 32'h221, 32'h011);
      rd(8'h10, 32'h122);
      test_done;
   end
endmodule
